// *** rtl/acl_tcp_udp_entry_matcher.sv ***
// Operation
// - Source port don't-care ignores the frame source port.
// - Source port single value matches only an equal source port.
// - Source port range matches only a source port inside the range.
// - Destination port don't-care ignores the frame destination port.
// - Destination port single value matches only an equal destination port.
// - Destination port range matches only a destination port inside the range.
// - FIN: 0 forbids FIN set, 1 requires it, don't-care ignores it.
// - SYN: 0 forbids SYN set, 1 requires it, don't-care ignores it.
// - PSH: 0 forbids PSH set, 1 requires it, don't-care ignores it.
// - ACK: 0 forbids ACK set, 1 requires it, don't-care ignores it.
// - URG: 0 forbids URG set, 1 requires it, don't-care ignores it.
//
// The address map and the strobed register port are this design's own decisions.
module acl_tcp_udp_entry_matcher (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Parsed frame from the parser
  input wire logic frame_valid,
  input wire logic frame_is_tcp,
  input wire logic frame_is_udp,
  input wire logic [15:0] frame_src_port,
  input wire logic [15:0] frame_dst_port,
  input wire logic [4:0] frame_flags,
  // Match result
  output logic result_valid,
  output logic entry_hit
);

  // ==========================================
  // Configuration registers
  logic [1:0] src_mode;
  logic [1:0] dst_mode;
  logic [15:0] src_lo;
  logic [15:0] src_hi;
  logic [15:0] dst_lo;
  logic [15:0] dst_hi;
  logic [9:0] flag_cfg;
  logic [31:0] hit_count;
  logic last_hit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_mode <= acl_match_pkg::PORT_ANY;
      dst_mode <= acl_match_pkg::PORT_ANY;
      src_lo <= acl_match_pkg::FIELD_RESET[15:0];
      src_hi <= acl_match_pkg::PORT_MAX_RESET;
      dst_lo <= acl_match_pkg::FIELD_RESET[15:0];
      dst_hi <= acl_match_pkg::PORT_MAX_RESET;
      flag_cfg <= acl_match_pkg::FIELD_RESET[9:0];
    end else if (reg_wr) begin
      unique case (reg_addr)
        acl_match_pkg::ADDR_PORT_CTRL: begin
          src_mode <= reg_wdata[acl_match_pkg::SRC_MODE_LSB +: acl_match_pkg::MODE_W];
          dst_mode <= reg_wdata[acl_match_pkg::DST_MODE_LSB +: acl_match_pkg::MODE_W];
        end
        acl_match_pkg::ADDR_SRC_LO: src_lo <= reg_wdata[15:0];
        acl_match_pkg::ADDR_SRC_HI: src_hi <= reg_wdata[15:0];
        acl_match_pkg::ADDR_DST_LO: dst_lo <= reg_wdata[15:0];
        acl_match_pkg::ADDR_DST_HI: dst_hi <= reg_wdata[15:0];
        acl_match_pkg::ADDR_FLAG_CTRL: flag_cfg <= reg_wdata[9:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= acl_match_pkg::FIELD_RESET;
    end else if (reg_rd) begin
      unique case (reg_addr)
        acl_match_pkg::ADDR_PORT_CTRL: reg_rdata <= {28'h0, dst_mode, src_mode};
        acl_match_pkg::ADDR_SRC_LO: reg_rdata <= {16'h0, src_lo};
        acl_match_pkg::ADDR_SRC_HI: reg_rdata <= {16'h0, src_hi};
        acl_match_pkg::ADDR_DST_LO: reg_rdata <= {16'h0, dst_lo};
        acl_match_pkg::ADDR_DST_HI: reg_rdata <= {16'h0, dst_hi};
        acl_match_pkg::ADDR_FLAG_CTRL: reg_rdata <= {22'h0, flag_cfg};
        acl_match_pkg::ADDR_STATUS: reg_rdata <= {31'h0, last_hit};
        acl_match_pkg::ADDR_HIT_COUNT: reg_rdata <= hit_count;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================
  // Match functions
  function automatic logic port_ok(input logic [1:0] mode, input logic [15:0] value,
                                   input logic [15:0] lo, input logic [15:0] hi);
    logic ok;
    ok = 1'b1;
    unique case (mode)
      acl_match_pkg::PORT_SPECIFIC: ok = (value == lo);
      acl_match_pkg::PORT_RANGE: ok = (value >= lo) && (value <= hi);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  function automatic logic flag_ok(input logic [1:0] setting, input logic flag);
    logic ok;
    ok = 1'b1;
    unique case (setting)
      acl_match_pkg::FLAG_CLEAR: ok = !flag;
      acl_match_pkg::FLAG_SET: ok = flag;
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // Modes 0 and 3 both leave the port unfiltered
  function automatic logic mode_active(input logic [1:0] mode);
    return (mode == acl_match_pkg::PORT_SPECIFIC) || (mode == acl_match_pkg::PORT_RANGE);
  endfunction

  // Codes 0 and 3 both leave the flag unchecked
  function automatic logic flag_active(input logic [1:0] setting);
    return (setting == acl_match_pkg::FLAG_CLEAR) || (setting == acl_match_pkg::FLAG_SET);
  endfunction

  // ==========================================
  // Criteria evaluation
  logic is_l4;
  logic src_pass;
  logic dst_pass;
  logic [4:0] flag_pass;
  logic [4:0] flag_on;
  logic flags_used;
  logic ports_used;
  logic next_hit;

  assign is_l4 = frame_is_tcp || frame_is_udp;
  assign src_pass = port_ok(src_mode, frame_src_port, src_lo, src_hi);
  assign dst_pass = port_ok(dst_mode, frame_dst_port, dst_lo, dst_hi);
  assign ports_used = mode_active(src_mode) || mode_active(dst_mode);

  genvar gi;
  generate
    for (gi = 0; gi < acl_match_pkg::NUM_FLAGS; gi++) begin : g_flag
      assign flag_pass[gi] = flag_ok(flag_cfg[gi*acl_match_pkg::FLAG_W +: acl_match_pkg::FLAG_W],
                                     frame_flags[gi]);
      assign flag_on[gi] =
        flag_active(flag_cfg[gi*acl_match_pkg::FLAG_W +: acl_match_pkg::FLAG_W]);
    end
  endgenerate
  // Only codes 1 and 2 make the entry depend on a TCP header
  assign flags_used = |flag_on;

  // AND of criteria gated by header kind
  assign next_hit = src_pass && dst_pass && (&flag_pass) &&
                    (!ports_used || is_l4) && (!flags_used || frame_is_tcp);

  // ==========================================
  // Result and statistics
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      entry_hit <= 1'b0;
    end else begin
      result_valid <= frame_valid;
      entry_hit <= frame_valid && next_hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_hit <= 1'b0;
      hit_count <= acl_match_pkg::FIELD_RESET;
    end else if (frame_valid) begin
      last_hit <= next_hit;
      hit_count <= hit_count + {31'h0, next_hit};
    end
  end

  // ==========================================
  // Assertions
  // check
  a_hit_needs_valid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    entry_hit |-> result_valid) else $error("hit without result valid");

  a_src_equal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && src_mode == acl_match_pkg::PORT_SPECIFIC && frame_src_port != src_lo
    |=> !entry_hit) else $error("source single value mismatch hit");

  a_src_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && src_mode == acl_match_pkg::PORT_RANGE &&
    (frame_src_port < src_lo || frame_src_port > src_hi)
    |=> !entry_hit) else $error("source outside range hit");

  a_dst_equal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && dst_mode == acl_match_pkg::PORT_SPECIFIC && frame_dst_port != dst_lo
    |=> !entry_hit) else $error("destination single value mismatch hit");

  a_dst_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && dst_mode == acl_match_pkg::PORT_RANGE &&
    (frame_dst_port < dst_lo || frame_dst_port > dst_hi)
    |=> !entry_hit) else $error("destination outside range hit");

  a_fin_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[1:0] == acl_match_pkg::FLAG_CLEAR && frame_flags[0]
    |=> !entry_hit) else $error("FIN set hit despite clear setting");

  a_syn_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[3:2] == acl_match_pkg::FLAG_SET && !frame_flags[1]
    |=> !entry_hit) else $error("SYN clear hit despite set setting");

  a_psh_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[5:4] == acl_match_pkg::FLAG_CLEAR && frame_flags[2]
    |=> !entry_hit) else $error("PSH set hit despite clear setting");

  a_ack_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[7:6] == acl_match_pkg::FLAG_SET && !frame_flags[3]
    |=> !entry_hit) else $error("ACK clear hit despite set setting");

  a_urg_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[9:8] == acl_match_pkg::FLAG_CLEAR && frame_flags[4]
    |=> !entry_hit) else $error("URG set hit despite clear setting");

  a_all_any: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && src_mode == acl_match_pkg::PORT_ANY &&
    dst_mode == acl_match_pkg::PORT_ANY && flag_cfg == 10'h000
    |=> entry_hit) else $error("all don't-care entry missed");

  a_dst_any: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && is_l4 && !mode_active(dst_mode) && !flags_used &&
    src_mode == acl_match_pkg::PORT_SPECIFIC && frame_src_port == src_lo
    |=> entry_hit) else $error("destination don't-care missed");

  a_flags_need_tcp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flags_used && !frame_is_tcp
    |=> !entry_hit) else $error("flag criteria hit on non-TCP frame");

  a_ports_need_l4: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && ports_used && !frame_is_tcp && !frame_is_udp
    |=> !entry_hit) else $error("port criteria hit on frame without TCP or UDP");

  a_src_any: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && is_l4 && !mode_active(src_mode) && !flags_used &&
    dst_mode == acl_match_pkg::PORT_SPECIFIC && frame_dst_port == dst_lo
    |=> entry_hit) else $error("source don't-care missed");

  a_src_equal_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && is_l4 && src_mode == acl_match_pkg::PORT_SPECIFIC &&
    frame_src_port == src_lo && !mode_active(dst_mode) && !flags_used
    |=> entry_hit) else $error("source single value missed");

  a_src_range_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && is_l4 && src_mode == acl_match_pkg::PORT_RANGE &&
    frame_src_port >= src_lo && frame_src_port <= src_hi &&
    !mode_active(dst_mode) && !flags_used
    |=> entry_hit) else $error("source inside range missed");

  a_dst_equal_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && is_l4 && dst_mode == acl_match_pkg::PORT_SPECIFIC &&
    frame_dst_port == dst_lo && !mode_active(src_mode) && !flags_used
    |=> entry_hit) else $error("destination single value missed");

  a_dst_range_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && is_l4 && dst_mode == acl_match_pkg::PORT_RANGE &&
    frame_dst_port >= dst_lo && frame_dst_port <= dst_hi &&
    !mode_active(src_mode) && !flags_used
    |=> entry_hit) else $error("destination inside range missed");

  a_fin_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[1:0] == acl_match_pkg::FLAG_SET && !frame_flags[0]
    |=> !entry_hit) else $error("FIN clear hit despite set setting");

  a_syn_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[3:2] == acl_match_pkg::FLAG_CLEAR && frame_flags[1]
    |=> !entry_hit) else $error("SYN set hit despite clear setting");

  a_psh_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[5:4] == acl_match_pkg::FLAG_SET && !frame_flags[2]
    |=> !entry_hit) else $error("PSH clear hit despite set setting");

  a_ack_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[7:6] == acl_match_pkg::FLAG_CLEAR && frame_flags[3]
    |=> !entry_hit) else $error("ACK set hit despite clear setting");

  a_urg_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_valid && flag_cfg[9:8] == acl_match_pkg::FLAG_SET && !frame_flags[4]
    |=> !entry_hit) else $error("URG clear hit despite set setting");

  // Result strobe mirrors the frame strobe one cycle later
  a_result_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
    result_valid == $past(frame_valid)) else $error("result valid not one cycle after frame");

  // Counter steps by one on each hit and holds on a miss
  a_count_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    entry_hit |-> hit_count == $past(hit_count) + 32'h0000_0001) else $error("hit not counted");

  a_count_miss: assert property (@(posedge clk_sys) disable iff (!rst_n)
    result_valid && !entry_hit |-> $stable(hit_count)) else $error("miss changed hit count");

endmodule

// *** rtl/acl_match_pkg.sv ***
package acl_match_pkg;

  // ==========================================
  // Register map (word offsets as byte addresses)
  localparam logic [7:0] ADDR_PORT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC_LO = 8'h04;
  localparam logic [7:0] ADDR_SRC_HI = 8'h08;
  localparam logic [7:0] ADDR_DST_LO = 8'h0C;
  localparam logic [7:0] ADDR_DST_HI = 8'h10;
  localparam logic [7:0] ADDR_FLAG_CTRL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_HIT_COUNT = 8'h1C;

  // ==========================================
  // Field layout
  localparam int SRC_MODE_LSB = 0;
  localparam int DST_MODE_LSB = 2;
  localparam int MODE_W = 2;
  localparam int FLAG_W = 2;
  localparam int NUM_FLAGS = 5;
  localparam int PORT_W = 16;
  localparam logic [31:0] FIELD_RESET = 32'h0000_0000;
  localparam logic [15:0] PORT_MAX_RESET = 16'hFFFF;

  // Port filter modes
  localparam logic [1:0] PORT_ANY = 2'h0;
  localparam logic [1:0] PORT_SPECIFIC = 2'h1;
  localparam logic [1:0] PORT_RANGE = 2'h2;

  // Flag criterion settings; code 3 behaves as don't-care
  localparam logic [1:0] FLAG_ANY = 2'h0;
  localparam logic [1:0] FLAG_CLEAR = 2'h1;
  localparam logic [1:0] FLAG_SET = 2'h2;

  // Flag index in the frame flag vector
  localparam int FLAG_FIN = 0;
  localparam int FLAG_SYN = 1;
  localparam int FLAG_PSH = 2;
  localparam int FLAG_ACK = 3;
  localparam int FLAG_URG = 4;

endpackage

// *** dv/frame_parser_model.sv ***
module frame_parser_model (
  // Clock
  input wire logic clk_sys,
  // Parsed frame towards the matcher
  output logic frame_valid,
  output logic frame_is_tcp,
  output logic frame_is_udp,
  output logic [15:0] frame_src_port,
  output logic [15:0] frame_dst_port,
  output logic [4:0] frame_flags
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frame_valid = 1'b0;
    frame_is_tcp = 1'b0;
    frame_is_udp = 1'b0;
    frame_src_port = 16'h0000;
    frame_dst_port = 16'h0000;
    frame_flags = 5'h00;
  end

  // ==========================================
  // One frame for one cycle; fields are scrambled once valid drops
  task automatic send(input logic tcp, input logic udp, input logic [15:0] s,
                      input logic [15:0] d, input logic [4:0] f);
    @(posedge clk_sys);
    frame_valid <= 1'b1;
    frame_is_tcp <= tcp;
    frame_is_udp <= udp;
    frame_src_port <= s;
    frame_dst_port <= d;
    frame_flags <= f;
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    frame_is_tcp <= ~tcp;
    frame_is_udp <= ~udp;
    frame_src_port <= ~s;
    frame_dst_port <= ~d;
    frame_flags <= ~f;
  endtask
endmodule

// *** dv/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic fv, ftcp, fudp, result_valid, entry_hit;
  logic [15:0] fsrc, fdst;
  logic [4:0] fflags;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  acl_tcp_udp_entry_matcher i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_valid(fv), .frame_is_tcp(ftcp), .frame_is_udp(fudp), .frame_src_port(fsrc),
    .frame_dst_port(fdst), .frame_flags(fflags), .result_valid(result_valid),
    .entry_hit(entry_hit));
  frame_parser_model i_parser (.clk_sys(clk_sys), .frame_valid(fv), .frame_is_tcp(ftcp),
    .frame_is_udp(fudp), .frame_src_port(fsrc), .frame_dst_port(fdst), .frame_flags(fflags));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Checking and bus helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  task automatic frm(input logic tcp, input logic udp, input logic [15:0] s,
                     input logic [15:0] d, input logic [4:0] f, input logic exp);
    i_parser.send(tcp, udp, s, d, f);
    #1;
    chk("result_valid", {31'h0, result_valid}, 32'h1);
    chk("entry_hit", {31'h0, entry_hit}, {31'h0, exp});
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    rd(acl_match_pkg::ADDR_PORT_CTRL, 32'h0);
    rd(acl_match_pkg::ADDR_SRC_HI, 32'h0000_FFFF);
    rd(8'h20, 32'h0);
    frm(1'b1, 1'b0, 16'hFFFF, 16'h0000, 5'h1F, 1'b1);
    frm(1'b0, 1'b0, 16'h0001, 16'h0002, 5'h00, 1'b1);
    rd(acl_match_pkg::ADDR_STATUS, 32'h0000_0001);
    rd(acl_match_pkg::ADDR_HIT_COUNT, 32'h0000_0002);
  endtask

  task automatic t_port(input logic is_dst);
    logic [7:0] lo;
    logic [15:0] v[4];
    logic e[4];
    lo = is_dst ? acl_match_pkg::ADDR_DST_LO : acl_match_pkg::ADDR_SRC_LO;
    v = '{16'h1234, 16'h1235, 16'h0000, 16'hFFFF};
    e = '{1'b1, 1'b0, 1'b0, 1'b0};
    wr(acl_match_pkg::ADDR_PORT_CTRL, 32'(acl_match_pkg::PORT_SPECIFIC) << (is_dst ? 2 : 0));
    wr(lo, 32'h1234);
    rd(lo, 32'h0000_1234);
    for (int i = 0; i < 4; i++) begin
      frm(1'b1, 1'b0, is_dst ? 16'h7 : v[i], is_dst ? v[i] : 16'h7, 5'h0, e[i]);
    end
    wr(acl_match_pkg::ADDR_PORT_CTRL, 32'(acl_match_pkg::PORT_RANGE) << (is_dst ? 2 : 0));
    wr(lo, 32'h0000_0064);
    wr(lo + 8'h04, 32'h0000_00C8);
    v = '{16'h0064, 16'h00C8, 16'h0063, 16'h00C9};
    e = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      frm(1'b0, 1'b1, is_dst ? 16'h7 : v[i], is_dst ? v[i] : 16'h7, 5'h0, e[i]);
    end
    frm(1'b0, 1'b0, 16'h0096, 16'h0096, 5'h0, 1'b0);
    wr(acl_match_pkg::ADDR_PORT_CTRL, 32'h0);
  endtask

  task automatic t_flags;
    logic [4:0] b;
    for (int i = 0; i < 5; i++) begin
      b = 5'h01 << i;
      wr(acl_match_pkg::ADDR_FLAG_CTRL, 32'(acl_match_pkg::FLAG_CLEAR) << (2 * i));
      frm(1'b1, 1'b0, 16'h1, 16'h2, b, 1'b0);
      frm(1'b1, 1'b0, 16'h1, 16'h2, ~b, 1'b1);
      wr(acl_match_pkg::ADDR_FLAG_CTRL, 32'(acl_match_pkg::FLAG_SET) << (2 * i));
      frm(1'b1, 1'b0, 16'h1, 16'h2, b, 1'b1);
      frm(1'b1, 1'b0, 16'h1, 16'h2, ~b, 1'b0);
      frm(1'b0, 1'b1, 16'h1, 16'h2, b, 1'b0);
    end
    // SYN set, ACK clear, source port 80 all at once
    wr(acl_match_pkg::ADDR_FLAG_CTRL, 32'h0000_0048);
    wr(acl_match_pkg::ADDR_PORT_CTRL, 32'h1);
    wr(acl_match_pkg::ADDR_SRC_LO, 32'h0000_0050);
    frm(1'b1, 1'b0, 16'h0050, 16'h2, 5'h0A, 1'b0);
    frm(1'b1, 1'b0, 16'h0051, 16'h2, 5'h02, 1'b0);
    frm(1'b1, 1'b0, 16'h0050, 16'h2, 5'h02, 1'b1);
    rd(acl_match_pkg::ADDR_STATUS, 32'h1);
  endtask

  // Codes 3 act as don't-care; then a mid-run reset restores the defaults
  task automatic t_rerun;
    wr(acl_match_pkg::ADDR_PORT_CTRL, 32'h0000_000F);
    wr(acl_match_pkg::ADDR_FLAG_CTRL, 32'h0000_03FF);
    wr(acl_match_pkg::ADDR_DST_HI, 32'h0000_0010);
    frm(1'b0, 1'b0, 16'h1234, 16'h4321, 5'h1F, 1'b1);
    frm(1'b1, 1'b0, 16'h0000, 16'hFFFF, 5'h00, 1'b1);
    rd(acl_match_pkg::ADDR_FLAG_CTRL, 32'h0000_03FF);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(acl_match_pkg::ADDR_FLAG_CTRL, 32'h0000_0000);
    rd(acl_match_pkg::ADDR_DST_HI, 32'h0000_FFFF);
    rd(acl_match_pkg::ADDR_HIT_COUNT, 32'h0000_0000);
    frm(1'b0, 1'b1, 16'h0001, 16'h0002, 5'h1F, 1'b1);
    rd(acl_match_pkg::ADDR_HIT_COUNT, 32'h0000_0001);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_port(1'b0);
    t_port(1'b1);
    t_flags();
    t_rerun();
    wrap_up();
  end
endmodule
